// *** verilog/aic_pkg.sv ***
// constants and carrier types for analog input conditioning
// assumes percentages in 0.1 % steps and gains in 0.001 steps
package aic_pkg;

  // widths
  localparam int ADC_W  = 12;
  localparam int PCT_W  = 16;
  localparam int GAIN_W = 14;
  localparam int TAU_W  = 11;
  localparam int FN_W   = 5;
  localparam int FRAC_W = 16;

  // scaling figures
  localparam int PCT_FULL      = 1000;  // 100.0 %
  localparam int GAIN_MAX      = 9999;  // 9.999
  localparam int GAIN_UNITY    = 1000;  // 1.000
  localparam int TAU_MAX       = 1600;  // 16.00 s
  localparam int TAU_LSB_US    = 10000; // 0.01 s
  localparam int ADC_FULL_CODE = 4095;  // 10 V or 20 mA
  localparam int LZ_FLOOR_CODE = 819;   // 4 mA
  localparam int LZ_SPAN_CODE  = 3276;  // 16 mA

  // values after reset
  localparam logic [1:0]        RANGE_RST  = 2'h0;
  localparam logic [PCT_W-1:0]  OFFSET_RST = 16'h0000;
  localparam logic [GAIN_W-1:0] GAIN_RST   = 14'h03E8;
  localparam logic [TAU_W-1:0]  TAU_RST    = 11'h000;
  localparam logic [FN_W-1:0]   FN_RST     = 5'h00;

  // potentiometer function codes
  localparam logic [FN_W-1:0] FN_SPEED_REF = 5'h00;
  localparam logic [FN_W-1:0] FN_PLC_USE   = 5'h07;
  localparam logic [FN_W-1:0] FN_APP_FIRST = 5'h08;
  localparam logic [FN_W-1:0] FN_APP_LAST  = 5'h0F;

  typedef enum logic [1:0] {
    RNG_FULL      = 2'b00,
    RNG_LIVE0     = 2'b01,
    RNG_FULL_INV  = 2'b10,
    RNG_LIVE0_INV = 2'b11
  } aic_range_t;

  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] code;
  } aic_adc_t;

  typedef struct packed {
    logic                    valid;
    logic signed [PCT_W-1:0] value;
  } aic_pct_t;

  typedef struct packed {
    aic_range_t              range;
    logic signed [PCT_W-1:0] offset;
    logic [GAIN_W-1:0]       gain;
    logic [TAU_W-1:0]        tau;
  } aic_cfg_t;

  typedef struct packed {
    logic       speed_ref;
    logic       plc_use;
    logic [7:0] app_func;
  } aic_pot_fn_t;

endpackage : aic_pkg

// *** verilog/aic_lpf.sv ***
// first-order recursive low-pass, one update per valid sample
// assumes tau already limited to its range by the caller
`timescale 1ns/100ps
module aic_lpf #(
  parameter int SAMPLE_US = 1000
) (
  // clock and reset
  input  logic                            clk,
  input  logic                            rst_n,
  // sample in and time constant
  input  aic_pkg::aic_pct_t               in_s,
  input  logic [aic_pkg::TAU_W-1:0]       tau,
  // filtered value
  output logic signed [aic_pkg::PCT_W-1:0] y_q
);

  logic signed [31:0]               acc_q;
  logic signed [31:0]               acc_d;
  logic signed [aic_pkg::PCT_W-1:0] y_d;

  // step toward the sample by Ts/(tau+Ts); 16 fraction bits keep
  // small steps from stalling on long time constants
  always_comb
  begin
    logic signed [63:0] diff;
    logic signed [63:0] den;
    logic signed [63:0] step;
    logic signed [47:0] rnd;
    diff  = 64'sh0;
    den   = 64'sh1;
    step  = 64'sh0;
    rnd   = 48'sh0;
    acc_d = acc_q;
    if (in_s.valid)
    begin
      if (tau == aic_pkg::TAU_RST)
        acc_d = $signed({in_s.value, 16'h0000});
      else
      begin
        diff  = 64'($signed({in_s.value, 16'h0000})) - 64'(acc_q);
        den   = 64'($signed({1'b0, tau})) * 64'(aic_pkg::TAU_LSB_US)
              + 64'(SAMPLE_US);
        step  = diff * 64'(SAMPLE_US) / den;
        acc_d = acc_q + 32'(step);
      end
    end
    rnd = 48'(acc_d) + 48'sh8000;
    y_d = rnd[31:16];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_q <= 32'sh0;
      y_q   <= 16'sh0;
    end
    else
    begin
      acc_q <= acc_d;
      y_q   <= y_d;
    end
  end

  a_lpf_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    in_s.valid && tau == 11'h000 |=> y_q == $past(in_s.value))
    else $error("zero tau did not pass the sample through");

  a_lpf_converge: assert property (@(posedge clk) disable iff (!rst_n)
    in_s.valid && tau != 11'h000 && y_q <= in_s.value
    |=> y_q >= $past(y_q) && y_q <= $past(in_s.value))
    else $error("filter moved away from or past the sample");

  a_lpf_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !in_s.valid |=> $stable(y_q))
    else $error("filter changed without a sample");

endmodule : aic_lpf

// *** verilog/aic_analog_input_cond.sv ***
// analog input conditioning: scale, offset, gain, filter, route
// assumes converter samples synchronous to clk, one-cycle valid
//
// How it works
// - range 0: sample over full scale, offset, gain
// - range 1: minus 4 mA floor, over 16 mA
// - ranges 2,3: result is 100 % minus term
// - signed offset per input, added before gain
// - per-input low-pass, time constant up to 16 s
// - potentiometer value readable, limited to +-100 %
// - potentiometer function selector decoded to uses
// - potentiometer gain is final multiplier, default 1
// - potentiometer offset added before potentiometer gain
// - one time constant filters pot and frequency
// - gain per input, final multiplier in ranges 0,1 (ranges 2,3 invert after it), default 1
`timescale 1ns/100ps
module aic_analog_input_cond #(
  parameter int SAMPLE_US = 1000
) (
  // clock and reset
  input  logic                             clk,
  input  logic                             rst_n,
  // converter samples
  input  aic_pkg::aic_adc_t                ain1_sample,
  input  aic_pkg::aic_adc_t                ain2_sample,
  input  aic_pkg::aic_adc_t                pot_sample,
  input  aic_pkg::aic_pct_t                freq_sample,
  // general input settings
  input  logic [1:0]                       ain1_range_select,
  input  logic [1:0]                       ain2_range_select,
  input  logic signed [aic_pkg::PCT_W-1:0] ain1_offset,
  input  logic signed [aic_pkg::PCT_W-1:0] ain2_offset,
  input  logic [aic_pkg::GAIN_W-1:0]       ain1_gain,
  input  logic [aic_pkg::GAIN_W-1:0]       ain2_gain,
  input  logic [aic_pkg::TAU_W-1:0]        ain1_filter_tau,
  input  logic [aic_pkg::TAU_W-1:0]        ain2_filter_tau,
  // potentiometer settings
  input  logic signed [aic_pkg::PCT_W-1:0] pot_offset,
  input  logic [aic_pkg::GAIN_W-1:0]       pot_gain,
  input  logic [aic_pkg::TAU_W-1:0]        pot_freq_filter_tau,
  input  logic [aic_pkg::FN_W-1:0]         pot_function_select,
  // conditioned values
  output logic signed [aic_pkg::PCT_W-1:0] ain1_value,
  output logic signed [aic_pkg::PCT_W-1:0] ain2_value,
  output logic signed [aic_pkg::PCT_W-1:0] pot_value_readback,
  output logic signed [aic_pkg::PCT_W-1:0] freq_value,
  output aic_pkg::aic_pot_fn_t             pot_function
);

  // limit a wide intermediate to +-100.0 %
  function automatic logic signed [15:0] pct_sat(
    input logic signed [47:0] v
  );
    if (v > 48'(aic_pkg::PCT_FULL))
      pct_sat = 16'(aic_pkg::PCT_FULL);
    else if (v < -48'(aic_pkg::PCT_FULL))
      pct_sat = -16'(aic_pkg::PCT_FULL);
    else
      pct_sat = v[15:0];
  endfunction : pct_sat

  // out-of-range settings are pinned, never wrapped
  function automatic logic [13:0] gain_sat(input logic [13:0] g);
    if (g > 14'(aic_pkg::GAIN_MAX))
      gain_sat = 14'(aic_pkg::GAIN_MAX);
    else
      gain_sat = g;
  endfunction : gain_sat

  function automatic logic [10:0] tau_sat(input logic [10:0] t);
    if (t > 11'(aic_pkg::TAU_MAX))
      tau_sat = 11'(aic_pkg::TAU_MAX);
    else
      tau_sat = t;
  endfunction : tau_sat

  // raw code to percent, offset, gain, optional inversion
  function automatic logic signed [15:0] ain_scale(
    input aic_pkg::aic_range_t      rng,
    input logic [aic_pkg::ADC_W-1:0] code,
    input logic signed [15:0]       off,
    input logic [13:0]              gain
  );
    logic signed [31:0] num;
    logic signed [31:0] base;
    logic signed [47:0] prod;
    logic signed [47:0] term;
    num = $signed({{(32-aic_pkg::ADC_W){1'b0}}, code});
    if (rng[0])
    begin
      num  = (num - 32'(aic_pkg::LZ_FLOOR_CODE))
           * 32'(aic_pkg::PCT_FULL);
      base = num / 32'(aic_pkg::LZ_SPAN_CODE);
    end
    else
    begin
      num  = num * 32'(aic_pkg::PCT_FULL);
      base = num / 32'(aic_pkg::ADC_FULL_CODE);
    end
    prod = 48'(base + 32'(off))
         * 48'($signed({1'b0, gain}));
    term = prod / 48'(aic_pkg::GAIN_UNITY);
    if (rng[1])
      term = 48'(aic_pkg::PCT_FULL) - term;
    ain_scale = pct_sat(term);
  endfunction : ain_scale

  // settings are captured so reset shows the defaults
  aic_pkg::aic_cfg_t    ain1_cfg_q;
  aic_pkg::aic_cfg_t    ain1_cfg_d;
  aic_pkg::aic_cfg_t    ain2_cfg_q;
  aic_pkg::aic_cfg_t    ain2_cfg_d;
  aic_pkg::aic_cfg_t    pot_cfg_q;
  aic_pkg::aic_cfg_t    pot_cfg_d;
  aic_pkg::aic_pot_fn_t fn_q;
  aic_pkg::aic_pot_fn_t fn_d;

  // scaled samples ahead of the filters
  aic_pkg::aic_pct_t ain1_s_q;
  aic_pkg::aic_pct_t ain1_s_d;
  aic_pkg::aic_pct_t ain2_s_q;
  aic_pkg::aic_pct_t ain2_s_d;
  aic_pkg::aic_pct_t pot_s_q;
  aic_pkg::aic_pct_t pot_s_d;

  // settings capture with limits applied
  always_comb
  begin
    ain1_cfg_d.range  = aic_pkg::aic_range_t'(ain1_range_select);
    ain1_cfg_d.offset = pct_sat(48'(ain1_offset));
    ain1_cfg_d.gain   = gain_sat(ain1_gain);
    ain1_cfg_d.tau    = tau_sat(ain1_filter_tau);
    ain2_cfg_d.range  = aic_pkg::aic_range_t'(ain2_range_select);
    ain2_cfg_d.offset = pct_sat(48'(ain2_offset));
    ain2_cfg_d.gain   = gain_sat(ain2_gain);
    ain2_cfg_d.tau    = tau_sat(ain2_filter_tau);
    // the potentiometer only has the direct full-scale range
    pot_cfg_d.range   = aic_pkg::RNG_FULL;
    pot_cfg_d.offset  = pct_sat(48'(pot_offset));
    pot_cfg_d.gain    = gain_sat(pot_gain);
    pot_cfg_d.tau     = tau_sat(pot_freq_filter_tau);
  end

  // function decode; codes above the last legal one stay unused
  always_comb
  begin
    fn_d.speed_ref = (pot_function_select
                      == aic_pkg::FN_SPEED_REF);
    fn_d.plc_use   = (pot_function_select
                      == aic_pkg::FN_PLC_USE);
    fn_d.app_func  = 8'h00;
    if (pot_function_select >= aic_pkg::FN_APP_FIRST &&
        pot_function_select <= aic_pkg::FN_APP_LAST)
      fn_d.app_func = 8'(8'h01 << pot_function_select[2:0]);
  end

  // scaling stage; value holds between samples
  always_comb
  begin
    ain1_s_d.valid = ain1_sample.valid;
    ain1_s_d.value = ain1_s_q.value;
    ain2_s_d.valid = ain2_sample.valid;
    ain2_s_d.value = ain2_s_q.value;
    pot_s_d.valid  = pot_sample.valid;
    pot_s_d.value  = pot_s_q.value;
    if (ain1_sample.valid)
      ain1_s_d.value = ain_scale(ain1_cfg_q.range, ain1_sample.code,
                                 ain1_cfg_q.offset, ain1_cfg_q.gain);
    if (ain2_sample.valid)
      ain2_s_d.value = ain_scale(ain2_cfg_q.range, ain2_sample.code,
                                 ain2_cfg_q.offset, ain2_cfg_q.gain);
    if (pot_sample.valid)
      pot_s_d.value  = ain_scale(pot_cfg_q.range, pot_sample.code,
                                 pot_cfg_q.offset,
                                 pot_cfg_q.gain);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ain1_cfg_q <= '{aic_pkg::RNG_FULL, aic_pkg::OFFSET_RST,
                      aic_pkg::GAIN_RST, aic_pkg::TAU_RST};
      ain2_cfg_q <= '{aic_pkg::RNG_FULL, aic_pkg::OFFSET_RST,
                      aic_pkg::GAIN_RST, aic_pkg::TAU_RST};
      pot_cfg_q  <= '{aic_pkg::RNG_FULL, aic_pkg::OFFSET_RST,
                      aic_pkg::GAIN_RST, aic_pkg::TAU_RST};
      fn_q       <= '{1'b1, 1'b0, 8'h00};
      ain1_s_q   <= '0;
      ain2_s_q   <= '0;
      pot_s_q    <= '0;
    end
    else
    begin
      ain1_cfg_q <= ain1_cfg_d;
      ain2_cfg_q <= ain2_cfg_d;
      pot_cfg_q  <= pot_cfg_d;
      fn_q       <= fn_d;
      ain1_s_q   <= ain1_s_d;
      ain2_s_q   <= ain2_s_d;
      pot_s_q    <= pot_s_d;
    end
  end

  assign pot_function = fn_q;

  // one filter per path; pot and frequency share one tau
  aic_lpf #(.SAMPLE_US(SAMPLE_US)) u_ain1_lpf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (ain1_s_q),
    .tau   (ain1_cfg_q.tau),
    .y_q   (ain1_value)
  );

  aic_lpf #(.SAMPLE_US(SAMPLE_US)) u_ain2_lpf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (ain2_s_q),
    .tau   (ain2_cfg_q.tau),
    .y_q   (ain2_value)
  );

  aic_lpf #(.SAMPLE_US(SAMPLE_US)) u_pot_lpf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (pot_s_q),
    .tau   (pot_cfg_q.tau),
    .y_q   (pot_value_readback)
  );

  aic_lpf #(.SAMPLE_US(SAMPLE_US)) u_freq_lpf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (freq_sample),
    .tau   (pot_cfg_q.tau),
    .y_q   (freq_value)
  );

  a_range0_full: assert property (@(posedge clk) disable iff (!rst_n)
    ain1_sample.valid && ain1_cfg_q.range == aic_pkg::RNG_FULL &&
    ain1_sample.code == 12'hFFF && ain1_cfg_q.offset == 16'sh0 &&
    ain1_cfg_q.gain == 14'h03E8
    |=> ain1_s_q.value == 16'sh03E8)
    else $error("full-scale code did not give 100.0 %");

  a_live0_floor: assert property (@(posedge clk) disable iff (!rst_n)
    ain1_sample.valid && ain1_cfg_q.range == aic_pkg::RNG_LIVE0 &&
    ain1_sample.code == 12'h333 && ain1_cfg_q.offset == 16'sh0 &&
    ain1_cfg_q.gain == 14'h03E8
    |=> ain1_s_q.value == 16'sh0)
    else $error("4 mA floor did not give 0.0 %");

  a_inverse_max: assert property (@(posedge clk) disable iff (!rst_n)
    ain2_sample.valid && ain2_cfg_q.range == aic_pkg::RNG_FULL_INV &&
    ain2_sample.code == 12'h000 && ain2_cfg_q.offset == 16'sh0 &&
    ain2_cfg_q.gain == 14'h03E8
    |=> ain2_s_q.value == 16'sh03E8)
    else $error("inverse range minimum did not give 100.0 %");

  a_offset_add: assert property (@(posedge clk) disable iff (!rst_n)
    ain2_sample.valid && ain2_cfg_q.range == aic_pkg::RNG_FULL &&
    ain2_sample.code == 12'h000 && ain2_cfg_q.gain == 14'h03E8
    |=> ain2_s_q.value == $past(ain2_cfg_q.offset))
    else $error("offset not added to zero sample");

  a_gain_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ain1_sample.valid && ain1_cfg_q.gain == 14'h0000 &&
    !ain1_cfg_q.range[1]
    |=> ain1_s_q.value == 16'sh0)
    else $error("zero gain did not give 0.0 %");

  a_pot_offset: assert property (@(posedge clk) disable iff (!rst_n)
    pot_sample.valid && pot_sample.code == 12'h000 &&
    pot_cfg_q.gain == 14'h07D0 && pot_cfg_q.offset == 16'sh0064
    |=> pot_s_q.value == 16'sh00C8)
    else $error("pot offset not applied ahead of gain");

  a_pot_gain: assert property (@(posedge clk) disable iff (!rst_n)
    pot_sample.valid && pot_cfg_q.gain == 14'h0000
    |=> pot_s_q.value == 16'sh0)
    else $error("pot gain not the final multiplier");

  a_pot_bounds: assert property (@(posedge clk) disable iff (!rst_n)
    pot_value_readback <= 16'sh03E8 &&
    pot_value_readback >= -16'sh03E8)
    else $error("pot value outside +-100.0 %");

  a_pot_fn_decode: assert property (@(posedge clk) disable iff (!rst_n)
    pot_function_select == 5'h0A
    |=> pot_function.app_func == 8'h04 && !pot_function.speed_ref &&
        !pot_function.plc_use)
    else $error("function 10 did not select application 3");

  a_freq_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    freq_sample.valid && pot_cfg_q.tau == 11'h000
    |=> freq_value == $past(freq_sample.value))
    else $error("frequency path ignored shared time constant");

  a_pot_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    pot_s_q.valid && pot_cfg_q.tau == 11'h000
    |=> pot_value_readback == $past(pot_s_q.value))
    else $error("pot path not passed through at zero tau");

endmodule : aic_analog_input_cond

// *** testbench/aic_adc_model.sv ***
// converter model: hands one sample to the conditioning block on request
// assumes requests come by non-blocking assignment at the rising edge
`timescale 1ns/100ps
module aic_adc_model (
  // clock
  input  logic                      clk,
  // request from the bench
  input  logic                      fire,
  input  logic [aic_pkg::ADC_W-1:0] code,
  // sample towards the block
  output aic_pkg::aic_adc_t         smp
);
  initial smp = '0;

  // between samples the code lines toggle, so a read without valid is junk
  always @(posedge clk)
  begin
    if (fire)
      smp <= '{valid: 1'b1, code: code};
    else
      smp <= '{valid: 1'b0, code: ~smp.code};
  end
endmodule : aic_adc_model

// *** testbench/aic_analog_input_cond_tb.sv ***
// self-checking bench for the analog input conditioning block
// assumes one clock; converter samples come from aic_adc_model
`timescale 1ns/100ps
module aic_analog_input_cond_tb;
  localparam int TS = 1000;
  localparam int LIMIT = 40000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] fire = '0;
  logic [11:0] code_r [3] = '{default: '0};
  aic_pkg::aic_adc_t smp [3];
  aic_pkg::aic_pct_t freq_sample = '0;
  logic [1:0] rng [2] = '{default: '0};
  logic signed [15:0] offs [3] = '{default: '0};
  logic [13:0] gains [3] = '{default: 14'h03E8};
  logic [10:0] taus [3] = '{default: '0};
  logic [4:0] fn_sel = '0;
  logic signed [15:0] val [4];
  aic_pkg::aic_pot_fn_t pot_function;
  longint acc [4] = '{default: 0};
  logic [31:0] seed = 32'he61dd925;
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  // converter partners for the two general inputs and the potentiometer
  for (genvar g = 0; g < 3; g++)
  begin : g_adc
    aic_adc_model u_adc (.clk(clk), .fire(fire[g]), .code(code_r[g]),
                         .smp(smp[g]));
  end

  aic_analog_input_cond #(.SAMPLE_US(TS)) DUT (
    .clk(clk), .rst_n(rst_n),
    .ain1_sample(smp[0]), .ain2_sample(smp[1]), .pot_sample(smp[2]),
    .freq_sample(freq_sample),
    .ain1_range_select(rng[0]), .ain2_range_select(rng[1]),
    .ain1_offset(offs[0]), .ain2_offset(offs[1]),
    .ain1_gain(gains[0]), .ain2_gain(gains[1]),
    .ain1_filter_tau(taus[0]), .ain2_filter_tau(taus[1]),
    .pot_offset(offs[2]), .pot_gain(gains[2]),
    .pot_freq_filter_tau(taus[2]), .pot_function_select(fn_sel),
    .ain1_value(val[0]), .ain2_value(val[1]),
    .pot_value_readback(val[2]), .freq_value(val[3]),
    .pot_function(pot_function)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // reference scaling, integer division truncates toward zero like the block
  function automatic int scale(input int r, input int c, input int off,
                               input int g);
    int t;
    off = (off > 1000) ? 1000 : ((off < -1000) ? -1000 : off);
    g = (g > 9999) ? 9999 : g;
    t = (r & 1) ? (c - 819) * 1000 / 3276 : c * 1000 / 4095;
    t = (t + off) * g / 1000;
    if (r & 2)
      t = 1000 - t;
    return (t > 1000) ? 1000 : ((t < -1000) ? -1000 : t);
  endfunction : scale

  // reference first-order filter in 16.16, bypassed at zero time constant
  function automatic int filt(input int ch, input int x, input int tau);
    longint xs;
    xs = longint'(x) <<< 16;
    if (tau == 0)
      acc[ch] = xs;
    else
      acc[ch] = acc[ch] + (xs - acc[ch]) * TS / (tau * 10000 + TS);
    return int'((acc[ch] + 32768) >>> 16);
  endfunction : filt

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic cmp_pct(input logic signed [15:0] got, input int exp,
                         input int tol);
    checks++;
    if ((^got === 1'bx) || (int'(got) - exp > tol) ||
        (exp - int'(got) > tol))
    begin
      num_errors++;
      $display("MISMATCH t=%0t value %0d expected %0d", $time, got, exp);
    end
  endtask : cmp_pct

  task automatic cmp_fn(input aic_pkg::aic_pot_fn_t got,
                        input aic_pkg::aic_pot_fn_t exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t function %h expected %h", $time, got, exp);
    end
  endtask : cmp_fn

  // one converter sample; result stands three edges after the request
  task automatic run_adc(input int ch, input logic [11:0] c, input int tol);
    int r;
    int e;
    @(posedge clk);
    fire[ch] <= 1'b1;
    code_r[ch] <= c;
    @(posedge clk);
    fire[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    r = (ch == 2) ? 0 : int'(rng[ch]);
    e = filt(ch, scale(r, int'(c), int'(offs[ch]), int'(gains[ch])),
             int'(taus[ch]));
    cmp_pct(val[ch], e, tol);
  endtask : run_adc

  // upstream frequency value; answer one edge after it is taken
  task automatic run_freq(input logic signed [15:0] v, input int tol);
    @(posedge clk);
    freq_sample <= '{valid: 1'b1, value: v};
    @(posedge clk);
    freq_sample <= '{valid: 1'b0, value: ~v};
    #1;
    cmp_pct(val[3], filt(3, int'(v), int'(taus[2])), tol);
  endtask : run_freq

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin : main
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    cmp_pct(val[0], 0, 0);
    cmp_fn(pot_function,
           '{speed_ref: 1'b1, plc_use: 1'b0, app_func: 8'h00});
    // every selector code, unused ones decode to nothing
    for (int s = 0; s < 32; s++)
    begin
      @(posedge clk);
      fn_sel <= 5'(s);
      repeat (3) @(posedge clk);
      #1;
      cmp_fn(pot_function, '{speed_ref: s == 0, plc_use: s == 7,
             app_func: (s >= 8 && s <= 15) ? 8'(1 << (s - 8))
                                          : 8'h00});
    end
    // random settings over all ranges, offsets and gains past their limits
    for (int i = 0; i < 150; i++)
    begin
      int ch;
      ch = int'(rnd() % 3);
      // settings change at the edge; the block copies them one edge later
      @(posedge clk);
      if (ch < 2)
        rng[ch] <= 2'(rnd() % 4);
      offs[ch] <= 16'(int'(rnd() % 2201) - 1100);
      gains[ch] <= 14'(rnd() % 12000);
      if (ch < 2)
        run_adc(ch, 12'(rnd()), 0);
      else
        run_adc(ch, 12'(rnd()), 0);
      run_freq(16'(int'(rnd() % 2001) - 1000), 0);
    end
    // corner samples that random codes almost never reach
    @(posedge clk);
    rng <= '{2'h1, 2'h2};
    offs <= '{16'sh0000, 16'sh0000, 16'sh0064};
    gains <= '{14'h03E8, 14'h03E8, 14'h07D0};
    run_adc(0, 12'h333, 0);
    run_adc(1, 12'h000, 0);
    run_adc(2, 12'h000, 0);
    @(posedge clk);
    rng[1] <= 2'h0;
    offs[1] <= -16'sh0190;
    gains <= '{14'h0000, 14'h03E8, 14'h0000};
    run_adc(1, 12'h000, 0);
    run_adc(0, 12'hABC, 0);
    run_adc(2, 12'h7FF, 0);
    // filtered steps on one general input and the shared pot/freq filter
    @(posedge clk);
    offs <= '{default: '0};
    gains <= '{default: 14'h03E8};
    rng[0] <= 2'h0;
    taus <= '{11'h001, 11'h000, 11'h002};
    @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      run_adc(0, 12'hFFF, 1);
      run_adc(2, 12'hFFF, 1);
      run_freq(16'sh03E8, 1);
    end
    give_verdict();
  end
endmodule : aic_analog_input_cond_tb
